// File: verilog/timer_channel_flags_irq_polarity.sv
// channel 1 status flags, interrupt enables and pwm polarity of a dual 16-bit timer
//
// Summary of operation
// - set overflow when counter wraps from FFFFH to 0000H while counting
// - also set overflow when a match clear takes the counter from FFFFH to zero
// - writing one to a status flag leaves it unchanged
// - writing zero to a flag last read as zero does not clear it
// - writing zero to a flag read as one clears it; read state tracked per flag
// - capture function: match flags A, B set on selected edge of pins A, B
// - capture function: match flags C, D set on selected edge of pins C, D
// - underflow flag never set during input capture function
// - other functions: match flag set when counter equals its general register
// - underflow flag set on counter underflow, only in complementary pwm mode
// - with transfer controller servicing, match flag set after transfer completes
// - match interrupt enable bits pass or block their flag interrupts
// - polarity bits act only in pwm function, ignored otherwise
// - polarity bit zero gives low active output, one gives high active
// - status, interrupt enable and polarity registers reset to zero
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "timer_flags_regs.svh"
module timer_channel_flags_irq_polarity (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_sys_rst,
  input  wire logic [`TF_AXI_ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                     i_s_axi_awvalid,
  output logic                          o_s_axi_awready,
  input  wire logic [31:0]              i_s_axi_wdata,
  input  wire logic [3:0]               i_s_axi_wstrb,
  input  wire logic                     i_s_axi_wvalid,
  output logic                          o_s_axi_wready,
  output logic [1:0]                    o_s_axi_bresp,
  output logic                          o_s_axi_bvalid,
  input  wire logic                     i_s_axi_bready,
  input  wire logic [`TF_AXI_ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                     i_s_axi_arvalid,
  output logic                          o_s_axi_arready,
  output logic [31:0]                   o_s_axi_rdata,
  output logic [1:0]                    o_s_axi_rresp,
  output logic                          o_s_axi_rvalid,
  input  wire logic                     i_s_axi_rready,
  input  wire logic [15:0]              i_counter_ch1,
  input  wire logic                     i_count_tick,
  input  wire logic                     i_count_down,
  input  wire logic                     i_counter_clear,
  input  wire logic                     i_capture_mode,
  input  wire logic                     i_comp_pwm_mode,
  input  wire logic [15:0]              i_general_reg_a_ch1,
  input  wire logic [15:0]              i_general_reg_b_ch1,
  input  wire logic [15:0]              i_general_reg_c_ch1,
  input  wire logic [15:0]              i_general_reg_d_ch1,
  input  wire logic [3:0]               i_timer_pin_ch1,
  input  wire logic [1:0]               i_edge_sel_a,
  input  wire logic [1:0]               i_edge_sel_b,
  input  wire logic [1:0]               i_edge_sel_c,
  input  wire logic [1:0]               i_edge_sel_d,
  input  wire logic [3:0]               i_dtc_enable,
  input  wire logic [3:0]               i_dtc_done,
  input  wire logic                     i_pwm_mode_ch0,
  input  wire logic                     i_pwm_mode_ch1,
  input  wire logic [2:0]               i_pwm_active_ch0,
  input  wire logic [2:0]               i_pwm_active_ch1,
  output logic [2:0]                    o_pwm_out_ch0,
  output logic [2:0]                    o_pwm_out_ch1,
  output logic [4:0]                    o_irq_enable_ch0,
  output logic                          o_wrap_interrupt,
  output logic [3:0]                    o_match_interrupt,
  output logic                          o_irq
);
  // bus state
  timer_flags_pkg::wr_state_t wr_state_ff;
  timer_flags_pkg::wr_state_t nxt_wr_state;
  timer_flags_pkg::rd_state_t rd_state_ff;
  timer_flags_pkg::rd_state_t nxt_rd_state;
  logic                   aw_hold_ff;
  logic                   w_hold_ff;
  logic [`TF_IDX_W-1:0]   aw_idx_ff;
  logic [7:0]             w_data_ff;
  logic                   w_lane0_ff;
  logic                   awready_ff;
  logic                   wready_ff;
  logic                   arready_ff;
  logic [1:0]             bresp_ff;
  logic [31:0]            rdata_ff;
  logic [1:0]             rresp_ff;
  logic                   nxt_aw_hold;
  logic                   nxt_w_hold;
  logic [`TF_IDX_W-1:0]   nxt_aw_idx;
  logic [7:0]             nxt_w_data;
  logic                   nxt_w_lane0;
  logic                   nxt_awready;
  logic                   nxt_wready;
  logic                   nxt_arready;
  logic [1:0]             nxt_bresp;
  logic [31:0]            nxt_rdata;
  logic [1:0]             nxt_rresp;
  logic                   do_write;
  logic                   do_read;
  logic                   wr_hit;
  logic [`TF_IDX_W-1:0]   ar_idx;
  // register state
  logic [4:0]             ien0_ff;
  logic [2:0]             pol0_ff;
  logic [5:0]             flags_ff;
  logic [5:0]             seen_ff;
  logic [4:0]             ien1_ff;
  logic [2:0]             pol1_ff;
  logic [5:0]             evt_ff;
  logic [5:0]             mask_ff;
  logic [4:0]             nxt_ien0;
  logic [2:0]             nxt_pol0;
  logic [5:0]             nxt_flags;
  logic [5:0]             nxt_seen;
  logic [4:0]             nxt_ien1;
  logic [2:0]             nxt_pol1;
  logic [5:0]             nxt_evt;
  logic [5:0]             nxt_mask;
  logic [5:0]             hw_set;
  logic [5:0]             sw_clr;
  logic [3:0]             match_set;
  logic                   ovf_set;
  logic                   udf_set;
  logic                   wr_lane;
  // outputs
  logic [2:0]             pwm_ch0_ff;
  logic [2:0]             pwm_ch1_ff;
  logic                   wrap_irq_ff;
  logic [3:0]             match_irq_ff;
  logic                   irq_ff;
  logic [2:0]             nxt_pwm_ch0;
  logic [2:0]             nxt_pwm_ch1;
  logic                   nxt_wrap_irq;
  logic [3:0]             nxt_match_irq;
  logic                   nxt_irq;
  logic [15:0]            greg [4];
  logic [1:0]             esel [4];

  assign greg[0] = i_general_reg_a_ch1;
  assign greg[1] = i_general_reg_b_ch1;
  assign greg[2] = i_general_reg_c_ch1;
  assign greg[3] = i_general_reg_d_ch1;
  assign esel[0] = i_edge_sel_a;
  assign esel[1] = i_edge_sel_b;
  assign esel[2] = i_edge_sel_c;
  assign esel[3] = i_edge_sel_d;

  // one detector per match flag a to d
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_match
      match_event_gen u_match (
        .i_sys_clk     (i_sys_clk),
        .i_sys_rst     (i_sys_rst),
        .i_capture_mode(i_capture_mode),
        .i_pin         (i_timer_pin_ch1[g]),
        .i_edge_sel    (esel[g]),
        .i_count_tick  (i_count_tick),
        .i_counter     (i_counter_ch1),
        .i_general_reg (greg[g]),
        .i_dtc_enable  (i_dtc_enable[g]),
        .i_dtc_done    (i_dtc_done[g]),
        .o_set         (match_set[g])
      );
    end
  endgenerate

  // axi4-lite write and read channels
  always_comb begin
    nxt_aw_hold  = aw_hold_ff;
    nxt_w_hold   = w_hold_ff;
    nxt_aw_idx   = aw_idx_ff;
    nxt_w_data   = w_data_ff;
    nxt_w_lane0  = w_lane0_ff;
    nxt_wr_state = wr_state_ff;
    nxt_bresp    = bresp_ff;
    nxt_rd_state = rd_state_ff;
    nxt_rdata    = rdata_ff;
    nxt_rresp    = rresp_ff;
    ar_idx       = i_s_axi_araddr[`TF_AXI_ADDR_W-1:2];
    do_read      = i_s_axi_arvalid & arready_ff;
    if (i_s_axi_awvalid & awready_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_idx  = i_s_axi_awaddr[`TF_AXI_ADDR_W-1:2];
    end
    if (i_s_axi_wvalid & wready_ff) begin
      nxt_w_hold  = 1'b1;
      nxt_w_data  = i_s_axi_wdata[7:0];
      nxt_w_lane0 = i_s_axi_wstrb[0];
    end
    wr_hit = (aw_idx_ff == `TF_IDX_IEN_CH0) | (aw_idx_ff == `TF_IDX_POL_CH0) |
             (aw_idx_ff == `TF_IDX_FLAGS_CH1) | (aw_idx_ff == `TF_IDX_IEN_CH1) |
             (aw_idx_ff == `TF_IDX_POL_CH1) | (aw_idx_ff == `TF_IDX_IRQ_EVENT) |
             (aw_idx_ff == `TF_IDX_IRQ_MASK);
    do_write = 1'b0;
    case (wr_state_ff)
      timer_flags_pkg::WR_IDLE: begin
        if (aw_hold_ff & w_hold_ff) begin
          do_write     = 1'b1;
          nxt_aw_hold  = 1'b0;
          nxt_w_hold   = 1'b0;
          nxt_bresp    = wr_hit ? `TF_RESP_OKAY : `TF_RESP_SLVERR;
          nxt_wr_state = timer_flags_pkg::WR_RESP;
        end
      end
      timer_flags_pkg::WR_RESP: begin
        if (i_s_axi_bready) begin
          nxt_wr_state = timer_flags_pkg::WR_IDLE;
        end
      end
      default: nxt_wr_state = timer_flags_pkg::WR_IDLE;
    endcase
    case (rd_state_ff)
      timer_flags_pkg::RD_IDLE: begin
        if (do_read) begin
          nxt_rresp    = `TF_RESP_OKAY;
          nxt_rd_state = timer_flags_pkg::RD_DATA;
          case (ar_idx)
            `TF_IDX_IEN_CH0:   nxt_rdata = {27'h0000000, ien0_ff};
            `TF_IDX_POL_CH0:   nxt_rdata = {28'h0000000, pol0_ff, 1'b0};
            `TF_IDX_FLAGS_CH1: nxt_rdata = {26'h0000000, flags_ff};
            `TF_IDX_IEN_CH1:   nxt_rdata = {27'h0000000, ien1_ff};
            `TF_IDX_POL_CH1:   nxt_rdata = {28'h0000000, pol1_ff, 1'b0};
            `TF_IDX_IRQ_EVENT: nxt_rdata = {26'h0000000, evt_ff};
            `TF_IDX_IRQ_MASK:  nxt_rdata = {26'h0000000, mask_ff};
            default: begin
              nxt_rdata = 32'h00000000;
              nxt_rresp = `TF_RESP_SLVERR;
            end
          endcase
        end
      end
      timer_flags_pkg::RD_DATA: begin
        if (i_s_axi_rready) begin
          nxt_rd_state = timer_flags_pkg::RD_IDLE;
        end
      end
      default: nxt_rd_state = timer_flags_pkg::RD_IDLE;
    endcase
    nxt_awready = ~nxt_aw_hold & (nxt_wr_state == timer_flags_pkg::WR_IDLE);
    nxt_wready  = ~nxt_w_hold & (nxt_wr_state == timer_flags_pkg::WR_IDLE);
    nxt_arready = (nxt_rd_state == timer_flags_pkg::RD_IDLE);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wr_state_ff <= timer_flags_pkg::WR_IDLE;
      rd_state_ff <= timer_flags_pkg::RD_IDLE;
      aw_hold_ff  <= 1'b0;
      w_hold_ff   <= 1'b0;
      aw_idx_ff   <= 20'h00000;
      w_data_ff   <= 8'h00;
      w_lane0_ff  <= 1'b0;
      awready_ff  <= 1'b0;
      wready_ff   <= 1'b0;
      arready_ff  <= 1'b0;
      bresp_ff    <= `TF_RESP_OKAY;
      rdata_ff    <= 32'h00000000;
      rresp_ff    <= `TF_RESP_OKAY;
    end else begin
      wr_state_ff <= nxt_wr_state;
      rd_state_ff <= nxt_rd_state;
      aw_hold_ff  <= nxt_aw_hold;
      w_hold_ff   <= nxt_w_hold;
      aw_idx_ff   <= nxt_aw_idx;
      w_data_ff   <= nxt_w_data;
      w_lane0_ff  <= nxt_w_lane0;
      awready_ff  <= nxt_awready;
      wready_ff   <= nxt_wready;
      arready_ff  <= nxt_arready;
      bresp_ff    <= nxt_bresp;
      rdata_ff    <= nxt_rdata;
      rresp_ff    <= nxt_rresp;
    end
  end

  // flags, enables, polarity and interrupt registers
  always_comb begin
    wr_lane  = do_write & w_lane0_ff;
    // counting up through maximum, or cleared by match at maximum
    ovf_set  = ((i_count_tick & ~i_count_down) | i_counter_clear) &
               (i_counter_ch1 == `TF_CNT_MAX);
    udf_set  = i_count_tick & i_count_down & (i_counter_ch1 == `TF_CNT_ZERO) &
               i_comp_pwm_mode & ~i_capture_mode;
    hw_set   = {udf_set, ovf_set, match_set};
    // only zeros written over flags seen set clear them; ones do nothing
    sw_clr   = (wr_lane & (aw_idx_ff == `TF_IDX_FLAGS_CH1)) ?
               (~w_data_ff[5:0] & seen_ff) : 6'h00;
    nxt_flags = (flags_ff & ~sw_clr) | hw_set;
    nxt_seen  = (wr_lane & (aw_idx_ff == `TF_IDX_FLAGS_CH1)) ? 6'h00 : seen_ff;
    if (do_read & (ar_idx == `TF_IDX_FLAGS_CH1)) begin
      nxt_seen = nxt_seen | flags_ff;
    end
    nxt_evt  = ((do_read & (ar_idx == `TF_IDX_IRQ_EVENT)) ? 6'h00 : evt_ff) | hw_set;
    nxt_ien0 = ien0_ff;
    nxt_pol0 = pol0_ff;
    nxt_ien1 = ien1_ff;
    nxt_pol1 = pol1_ff;
    nxt_mask = mask_ff;
    if (wr_lane) begin
      case (aw_idx_ff)
        `TF_IDX_IEN_CH0:  nxt_ien0 = w_data_ff[4:0];
        `TF_IDX_POL_CH0:  nxt_pol0 = w_data_ff[`TF_POL_MSB:`TF_POL_LSB];
        `TF_IDX_IEN_CH1:  nxt_ien1 = w_data_ff[4:0];
        `TF_IDX_POL_CH1:  nxt_pol1 = w_data_ff[`TF_POL_MSB:`TF_POL_LSB];
        `TF_IDX_IRQ_MASK: nxt_mask = w_data_ff[5:0];
        default:          nxt_mask = mask_ff;
      endcase
    end
    // polarity applies only in pwm function: one high active, zero low active
    nxt_pwm_ch0   = i_pwm_mode_ch0 ? ~(i_pwm_active_ch0 ^ pol0_ff)
                                   : i_pwm_active_ch0;
    nxt_pwm_ch1   = i_pwm_mode_ch1 ? ~(i_pwm_active_ch1 ^ pol1_ff)
                                   : i_pwm_active_ch1;
    nxt_match_irq = flags_ff[`TF_FLAG_D:`TF_FLAG_A] & ien1_ff[3:0];
    nxt_wrap_irq  = ien1_ff[`TF_IEN_WRAP] &
                    (flags_ff[`TF_FLAG_OVF] | flags_ff[`TF_FLAG_UDF]);
    nxt_irq       = |(evt_ff & mask_ff);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flags_ff     <= `TF_RST_FLAGS;
      seen_ff      <= `TF_RST_FLAGS;
      ien0_ff      <= `TF_RST_IEN;
      ien1_ff      <= `TF_RST_IEN;
      pol0_ff      <= `TF_RST_POL;
      pol1_ff      <= `TF_RST_POL;
      evt_ff       <= `TF_RST_FLAGS;
      mask_ff      <= `TF_RST_MASK;
      pwm_ch0_ff   <= 3'h0;
      pwm_ch1_ff   <= 3'h0;
      match_irq_ff <= 4'h0;
      wrap_irq_ff  <= 1'b0;
      irq_ff       <= 1'b0;
    end else begin
      flags_ff     <= nxt_flags;
      seen_ff      <= nxt_seen;
      ien0_ff      <= nxt_ien0;
      ien1_ff      <= nxt_ien1;
      pol0_ff      <= nxt_pol0;
      pol1_ff      <= nxt_pol1;
      evt_ff       <= nxt_evt;
      mask_ff      <= nxt_mask;
      pwm_ch0_ff   <= nxt_pwm_ch0;
      pwm_ch1_ff   <= nxt_pwm_ch1;
      match_irq_ff <= nxt_match_irq;
      wrap_irq_ff  <= nxt_wrap_irq;
      irq_ff       <= nxt_irq;
    end
  end

  assign o_s_axi_awready   = awready_ff;
  assign o_s_axi_wready    = wready_ff;
  assign o_s_axi_bresp     = bresp_ff;
  assign o_s_axi_bvalid    = wr_state_ff[1];
  assign o_s_axi_arready   = arready_ff;
  assign o_s_axi_rdata     = rdata_ff;
  assign o_s_axi_rresp     = rresp_ff;
  assign o_s_axi_rvalid    = rd_state_ff[1];
  assign o_pwm_out_ch0     = pwm_ch0_ff;
  assign o_pwm_out_ch1     = pwm_ch1_ff;
  assign o_irq_enable_ch0  = ien0_ff;
  assign o_wrap_interrupt  = wrap_irq_ff;
  assign o_match_interrupt = match_irq_ff;
  assign o_irq             = irq_ff;
endmodule : timer_channel_flags_irq_polarity

// File: verilog/timer_flags_regs.svh
// register indexes, field positions, reset values and constants of the timer flag block
`ifndef TIMER_FLAGS_REGS_SVH
`define TIMER_FLAGS_REGS_SVH

`define TF_AXI_ADDR_W      22
`define TF_IDX_W           20
`define TF_IDX_IEN_CH0     20'hF0274
`define TF_IDX_POL_CH0     20'hF0275
`define TF_IDX_FLAGS_CH1   20'hF0283
`define TF_IDX_IEN_CH1     20'hF0284
`define TF_IDX_POL_CH1     20'hF0285
`define TF_IDX_IRQ_EVENT   20'hF0290
`define TF_IDX_IRQ_MASK    20'hF0291

`define TF_FLAG_A          0
`define TF_FLAG_D          3
`define TF_FLAG_OVF        4
`define TF_FLAG_UDF        5
`define TF_IEN_WRAP        4
`define TF_POL_LSB         1
`define TF_POL_MSB         3

`define TF_RST_FLAGS       6'h00
`define TF_RST_IEN         5'h00
`define TF_RST_POL         3'h0
`define TF_RST_MASK        6'h00

`define TF_CNT_MAX         16'hFFFF
`define TF_CNT_ZERO        16'h0000
`define TF_RESP_OKAY       2'h0
`define TF_RESP_SLVERR     2'h2

`endif

// File: verilog/timer_flags_pkg.sv
// types of the timer flag block
package timer_flags_pkg;
  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_ANY  = 2'h3
  } edge_sel_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } rd_state_t;
endpackage : timer_flags_pkg

// File: verilog/match_event_gen.sv
// capture edge or compare match detection for one match flag, with transfer deferral
`timescale 1ns/10ps
module match_event_gen (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_capture_mode,
  input  wire logic        i_pin,
  input  wire logic [1:0]  i_edge_sel,
  input  wire logic        i_count_tick,
  input  wire logic [15:0] i_counter,
  input  wire logic [15:0] i_general_reg,
  input  wire logic        i_dtc_enable,
  input  wire logic        i_dtc_done,
  output logic             o_set
);
  logic pin_prev_ff;
  logic pending_ff;
  logic set_ff;
  logic nxt_pin_prev;
  logic nxt_pending;
  logic nxt_set;
  logic edge_hit;
  logic event_now;

  always_comb begin
    nxt_pin_prev = i_pin;
    case (timer_flags_pkg::edge_sel_t'(i_edge_sel))
      timer_flags_pkg::EDGE_RISE: edge_hit = i_pin & ~pin_prev_ff;
      timer_flags_pkg::EDGE_FALL: edge_hit = ~i_pin & pin_prev_ff;
      default:                    edge_hit = i_pin ^ pin_prev_ff;
    endcase
    // capture edge or counter equal to general register
    event_now = i_capture_mode ? edge_hit
                               : (i_count_tick & (i_counter == i_general_reg));
    if (i_dtc_enable) begin
      // flag set only once the transfer has completed
      nxt_set     = i_dtc_done & pending_ff;
      nxt_pending = (pending_ff & ~i_dtc_done) | event_now;
    end else begin
      nxt_set     = event_now;
      nxt_pending = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pin_prev_ff <= 1'b0;
      pending_ff  <= 1'b0;
      set_ff      <= 1'b0;
    end else begin
      pin_prev_ff <= nxt_pin_prev;
      pending_ff  <= nxt_pending;
      set_ff      <= nxt_set;
    end
  end

  assign o_set = set_ff;
endmodule : match_event_gen

// File: tb/timer_flags_checker.sv
// concurrent checks on the bus and pwm ports of the timer flag block
`timescale 1ns/10ps
module timer_flags_checker (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_s_axi_awvalid,
  input  wire logic        o_s_axi_awready,
  input  wire logic        i_s_axi_wvalid,
  input  wire logic        o_s_axi_wready,
  input  wire logic [1:0]  o_s_axi_bresp,
  input  wire logic        o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic        i_s_axi_arvalid,
  input  wire logic        o_s_axi_arready,
  input  wire logic [31:0] o_s_axi_rdata,
  input  wire logic        o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic        i_pwm_mode_ch1,
  input  wire logic [2:0]  i_pwm_active_ch1,
  input  wire logic [2:0]  o_pwm_out_ch1
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_ar_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  sequence s_wr_take;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  a_rd_latency: assert property (s_ar_take |=> o_s_axi_rvalid)
    else $error("read answer not one cycle after address");
  a_wr_latency: assert property (s_wr_take |-> ##2 o_s_axi_bvalid)
    else $error("write answer not two cycles after address and data");
  a_rd_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read answer dropped");
  a_wr_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
  a_rd_refuse: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read address accepted while answer pending");
  a_wr_refuse: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write accepted while answer pending");
  a_ready_rst: assert property ($fell(i_sys_rst) |=> o_s_axi_awready && o_s_axi_arready)
    else $error("not ready after reset");
  a_rdata_upper: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_pwm_pass: assert property (!i_pwm_mode_ch1 |=>
    o_pwm_out_ch1 == $past(i_pwm_active_ch1)) else $error("pwm output altered outside pwm");
endmodule : timer_flags_checker

// File: tb/timer_channel_flags_irq_polarity_tb.sv
// self-checking bench of the timer flag block
`timescale 1ns/10ps
`include "timer_flags_regs.svh"
module timer_channel_flags_irq_polarity_tb;
  localparam logic [19:0] FL = `TF_IDX_FLAGS_CH1;
  localparam logic [19:0] IE1 = `TF_IDX_IEN_CH1;
  logic [19:0] ra [5] = '{`TF_IDX_IEN_CH0, `TF_IDX_POL_CH0, FL, IE1, `TF_IDX_POL_CH1};
  logic        i_sys_clk = 1'h0, i_sys_rst = 1'h1;
  logic [21:0] i_s_axi_awaddr = 22'h0, i_s_axi_araddr = 22'h0;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
  logic [3:0]  i_s_axi_wstrb = 4'hF, i_timer_pin_ch1 = 4'h0, i_dtc_enable = 4'h0;
  logic [3:0]  i_dtc_done = 4'h0, o_match_interrupt;
  logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic        i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0, i_count_tick = 1'h0;
  logic        i_count_down = 1'h0, i_counter_clear = 1'h0, i_capture_mode = 1'h0;
  logic        i_comp_pwm_mode = 1'h0, i_pwm_mode_ch0 = 1'h0, i_pwm_mode_ch1 = 1'h0;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic        o_s_axi_rvalid, o_wrap_interrupt, o_irq;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [1:0]  i_edge_sel_a = 2'h0, i_edge_sel_b = 2'h1, i_edge_sel_c = 2'h2, i_edge_sel_d = 2'h3;
  logic [15:0] i_counter_ch1 = 16'h8000, i_general_reg_a_ch1, i_general_reg_b_ch1;
  logic [15:0] i_general_reg_c_ch1, i_general_reg_d_ch1;
  logic [2:0]  i_pwm_active_ch0 = 3'h0, i_pwm_active_ch1 = 3'h0, o_pwm_out_ch0, o_pwm_out_ch1;
  logic [4:0]  o_irq_enable_ch0;
  logic [33:0] exp_q[$], msk_q[$];
  int          err_count = 0, n_checks = 0, seed = 32'h4E06;

  timer_channel_flags_irq_polarity uut (.*);

  always #5 i_sys_clk = ~i_sys_clk;

  task chk(input string nm, input logic [33:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task wr(input logic [19:0] ix, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge i_sys_clk);
    i_s_axi_awaddr <= {ix, 2'h0};
    i_s_axi_wdata <= {24'h0, d};
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    i_s_axi_bready <= 1'($random(seed));
    do begin
      @(posedge i_sys_clk);
      if (o_s_axi_awready === 1'h1) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready === 1'h1) i_s_axi_wvalid <= 1'h0;
    end while (i_s_axi_awvalid || i_s_axi_wvalid);
    do begin
      @(posedge i_sys_clk);
      i_s_axi_bready <= 1'h1;
    end while (o_s_axi_bvalid !== 1'h1 || i_s_axi_bready !== 1'h1);
    chk("bresp", o_s_axi_bresp, er);
    i_s_axi_bready <= 1'h0;
  endtask : wr

  task rd(input logic [19:0] ix, input logic [33:0] e, m = 34'h3FFFFFFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge i_sys_clk);
    i_s_axi_araddr <= {ix, 2'h0};
    i_s_axi_arvalid <= 1'h1;
    i_s_axi_rready <= 1'($random(seed));
    do @(posedge i_sys_clk); while (o_s_axi_arready !== 1'h1);
    i_s_axi_arvalid <= 1'h0;
    do begin
      @(posedge i_sys_clk);
      i_s_axi_rready <= 1'h1;
    end while (o_s_axi_rvalid !== 1'h1 || i_s_axi_rready !== 1'h1);
    i_s_axi_rready <= 1'h0;
  endtask : rd

  // one counter step or match clear at value c, then settle
  task ev(input logic [15:0] c, input logic dn, cl);
    @(posedge i_sys_clk);
    i_counter_ch1 <= c;
    i_count_down <= dn;
    i_count_tick <= !cl;
    i_counter_clear <= cl;
    @(posedge i_sys_clk);
    i_counter_ch1 <= 16'h8000;
    i_count_tick <= 1'h0;
    i_counter_clear <= 1'h0;
    repeat (4) @(posedge i_sys_clk);
    #1;
  endtask : ev

  task st;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask : st

  task cl;
    rd(FL, 34'h0, 34'h0);
    wr(FL, 8'h00);
  endtask : cl

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  always @(posedge i_sys_clk) begin
    if (o_s_axi_rvalid === 1'h1 && i_s_axi_rready === 1'h1 && exp_q.size() > 0) begin
      chk("rdata", {o_s_axi_rresp, o_s_axi_rdata} & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // the tests need about 300 cycles; 10000 means a hang
  initial begin
    #100000;
    err_count++;
    print_verdict;
  end

  initial begin
    i_general_reg_a_ch1 = 16'($random(seed)) & 16'h3FFF | 16'h0010;
    i_general_reg_b_ch1 = i_general_reg_a_ch1 + 16'h1000;
    i_general_reg_c_ch1 = i_general_reg_a_ch1 + 16'h2000;
    i_general_reg_d_ch1 = i_general_reg_a_ch1 + 16'h3000;
    repeat (8) @(posedge i_sys_clk);
    i_sys_rst <= 1'h0;
    foreach (ra[i]) rd(ra[i], 34'h0);
    rd(20'h00100, 34'h200000000);
    wr(20'h00100, 8'h00, 2'h2);
    wr(IE1, 8'h1F);
    wr(`TF_IDX_IRQ_MASK, 8'h01);
    wr(`TF_IDX_POL_CH1, 8'h0B);
    wr(`TF_IDX_IEN_CH0, 8'h13);
    rd(IE1, 34'h1F);
    rd(`TF_IDX_POL_CH1, 34'h0A);
    rd(`TF_IDX_IEN_CH0, 34'h13);
    i_s_axi_wstrb <= 4'hE;
    wr(IE1, 8'h00);
    i_s_axi_wstrb <= 4'hF;
    rd(IE1, 34'h1F);
    st;
    chk("ien_ch0", o_irq_enable_ch0, 5'h13);
    $display("test registers done");
    ev(i_general_reg_a_ch1, 1'h0, 1'h0);
    chk("match_irq", o_match_interrupt, 4'h1);
    chk("irq", o_irq, 1'h1);
    wr(FL, 8'h00);
    rd(FL, 34'h01);
    wr(FL, 8'hFF);
    rd(FL, 34'h01);
    ev(i_general_reg_b_ch1, 1'h0, 1'h0);
    wr(FL, 8'h00);
    rd(FL, 34'h02);
    wr(IE1, 8'h11);
    st;
    chk("match_irq", o_match_interrupt, 4'h0);
    rd(`TF_IDX_IRQ_EVENT, 34'h01, 34'h300000001);
    st;
    chk("irq", o_irq, 1'h0);
    cl;
    wr(IE1, 8'h1F);
    $display("test match and clear done");
    for (int k = 0; k < 2; k++) begin
      ev(16'hFFFF, 1'h0, k[0]);
      chk("wrap_irq", o_wrap_interrupt, 1'h1);
      chk("irq", o_irq, 1'h0);
      rd(FL, 34'h10);
      cl;
    end
    i_comp_pwm_mode <= 1'h1;
    ev(16'h0000, 1'h1, 1'h0);
    chk("wrap_irq", o_wrap_interrupt, 1'h1);
    rd(FL, 34'h20);
    cl;
    i_capture_mode <= 1'h1;
    ev(16'h0000, 1'h1, 1'h0);
    rd(FL, 34'h00);
    i_comp_pwm_mode <= 1'h0;
    i_timer_pin_ch1 <= 4'hF;
    repeat (4) @(posedge i_sys_clk);
    rd(FL, 34'h0D);
    cl;
    i_timer_pin_ch1 <= 4'h0;
    repeat (4) @(posedge i_sys_clk);
    rd(FL, 34'h0E);
    cl;
    i_capture_mode <= 1'h0;
    i_dtc_enable <= 4'h1;
    $display("test wrap and capture done");
    ev(i_general_reg_a_ch1, 1'h0, 1'h0);
    rd(FL, 34'h00);
    i_dtc_done <= 4'h1;
    @(posedge i_sys_clk);
    i_dtc_done <= 4'h0;
    st;
    rd(FL, 34'h01);
    cl;
    i_dtc_enable <= 4'h0;
    for (int j = 0; j < 2; j++) begin
      @(posedge i_sys_clk);
      i_pwm_mode_ch0 <= j[0];
      i_pwm_mode_ch1 <= j[0];
      i_pwm_active_ch0 <= 3'($random(seed));
      i_pwm_active_ch1 <= 3'($random(seed));
      st;
      chk("pwm_ch1", o_pwm_out_ch1, i_pwm_active_ch1 ^ (j ? 3'h2 : 3'h0));
      chk("pwm_ch0", o_pwm_out_ch0, i_pwm_active_ch0 ^ (j ? 3'h7 : 3'h0));
    end
    $display("test transfer and polarity done");
    print_verdict;
  end
endmodule : timer_channel_flags_irq_polarity_tb

bind timer_channel_flags_irq_polarity timer_flags_checker chk_i (.*);
